/* File: src/rss_filter.sv */
// Pulse-width filter for the external reset pin, after synchronising.
// Assumes the raw pin is asynchronous to clk_in.
`include "rss_map.svh"
`default_nettype none
module rss_filter #(
  parameter int MIN_CYC = `RSS_PIN_MIN_CYC
) (
  // Clock and reset
  input  wire logic clk_in,
  input  wire logic rstn_in,
  // Pin and result
  input  wire logic pin_n_in,
  output logic      long_low_out
);
  logic       sync1;
  logic       sync2;
  logic [7:0] cnt;
  logic [7:0] next_cnt;
  logic       next_long_low;

  always_comb
  begin
    next_cnt = 8'h00;
    next_long_low = 1'b0;
    if (!sync2)
    begin
      next_cnt = (cnt == 8'(MIN_CYC)) ? cnt : cnt + 8'h01;
      next_long_low = (next_cnt == 8'(MIN_CYC));
    end
  end

  always_ff @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      sync1 <= 1'b1;
      sync2 <= 1'b1;
      cnt <= 8'h00;
      long_low_out <= 1'b0;
    end
    else
    begin
      sync1 <= pin_n_in;
      sync2 <= sync1;
      cnt <= next_cnt;
      long_low_out <= next_long_low;
    end
  end
endmodule
`default_nettype wire

/* File: src/rss_map.svh */
// Constants for the reset source sequencer: flag positions, fuse codes,
// timing counts.
// Assumes a 10 MHz clk_in; included by the design modules.
`ifndef RSS_MAP_SVH
`define RSS_MAP_SVH

// ******************************************************************
// Cause flag positions
// ******************************************************************
`define RSS_FLAG_SUPPLY_UP 0
`define RSS_FLAG_EXTERNAL  1
`define RSS_FLAG_BROWNOUT  2
`define RSS_FLAG_WATCHDOG  3
`define RSS_FLAG_SCAN      4
`define RSS_NUM_SOURCES    5
`define RSS_CAUSE_RESET    5'h00

// ******************************************************************
// Fuse codes and timing
// ******************************************************************
`define RSS_BOD_DISABLED   3'h7
`define RSS_CLK_HZ         10000000
`define RSS_TOUT_SHORT_US  65
`define RSS_TOUT_LONG_US   4100
`define RSS_PIN_MIN_NS     2500
`define RSS_PIN_MIN_CYC    ((`RSS_PIN_MIN_NS * 10 + 999) / 1000)

`endif

/* File: src/rss_pkg.sv */
// Types shared by the reset source sequencer.
// Assumes nothing beyond the map header.
`default_nettype none
package rss_pkg;
  typedef enum logic [2:0] {
    RSS_IDLE, RSS_RSVD1, RSS_PDOWN, RSS_PSAVE,
    RSS_RSVD4, RSS_RSVD5, RSS_STBY, RSS_XSTBY
  } rss_sleep_e;
  typedef enum logic [1:0] {RSS_HOLD, RSS_STRETCH, RSS_RUN} rss_state_e;
endpackage
`default_nettype wire

/* File: src/rss_top.sv */
// Reset source sequencer: combines reset sources, stretches the internal
// reset, keeps cause flags and drives sleep-related enables.
// Assumes rstn_in is the power-on detector output (low = supply low),
// and the other inputs are on clk_in unless named as pins.
`include "rss_map.svh"
`default_nettype none
module rss_top #(
  parameter int TOUT_SHORT_CYC =
    (`RSS_TOUT_SHORT_US * (`RSS_CLK_HZ / 1000000)),
  parameter int TOUT_LONG_CYC =
    (`RSS_TOUT_LONG_US * (`RSS_CLK_HZ / 1000000))
) (
  // Clock and power-on reset
  input  wire logic       clk_in,
  input  wire logic       rstn_in,
  // Reset sources
  input  wire logic       ext_reset_n_in,
  input  wire logic       wdt_expire_in,
  input  wire logic       wdt_enable_in,
  input  wire logic       bod_low_in,
  input  wire logic       scan_reset_reg_in,
  // Fuses
  input  wire logic [3:0] clock_select_fuses_in,
  input  wire logic [2:0] brownout_level_fuses_in,
  input  wire logic       onchip_debug_fuse_in,
  input  wire logic       scan_iface_enable_fuse_in,
  // Software control
  input  wire logic       scan_iface_disable_bit_in,
  input  wire logic [4:0] cause_write_in,
  input  wire logic [4:0] cause_wdata_in,
  input  wire logic       sleep_in,
  input  wire logic [2:0] sleep_mode_in,
  input  wire logic       comp_disable_in,
  input  wire logic       comp_use_ref_in,
  input  wire logic       wake_pin_need_in,
  // Scan port
  input  wire logic       scan_shifting_in,
  input  wire logic       scan_tdo_in,
  output logic            scan_tdo_out,
  output logic            scan_tdo_oe_n_out,
  output logic            scan_iface_en_out,
  // Reset outputs
  output logic            port_reset_n_out,
  output logic            core_reset_n_out,
  output logic            fetch_from_vector_out,
  output logic [4:0]      reset_cause_register_out,
  // Sleep gating outputs
  output logic            main_clk_keep_out,
  output logic            input_buf_en_out,
  output logic            comp_en_out,
  output logic            vref_en_out,
  output logic            bod_en_out,
  output logic            wdt_run_out
);

  // ****************************************************************
  // Source collection
  // ****************************************************************
  logic ext_long_low;
  logic bod_enabled;
  logic wdt_pulse;
  logic wdt_pulse_d;
  logic any_request;
  logic [4:0] src_vec;

  rss_filter #(.MIN_CYC(`RSS_PIN_MIN_CYC)) u_filter (
    .clk_in       (clk_in),
    .rstn_in      (rstn_in),
    .pin_n_in     (ext_reset_n_in),
    .long_low_out (ext_long_low)
  );

  assign bod_enabled = (brownout_level_fuses_in != `RSS_BOD_DISABLED);

  // Edge of the expiry request while wdt_enable_in is high gives exactly one clock of pulse
  logic wdt_expire_d;
  logic next_wdt_pulse;
  always_comb
  begin
    next_wdt_pulse = wdt_expire_in & ~wdt_expire_d & wdt_enable_in;
  end

  always_ff @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      wdt_expire_d <= 1'b0;
      wdt_pulse <= 1'b0;
      wdt_pulse_d <= 1'b0;
    end
    else
    begin
      wdt_expire_d <= wdt_expire_in;
      wdt_pulse <= next_wdt_pulse;
      wdt_pulse_d <= wdt_pulse;
    end
  end

  always_comb
  begin
    src_vec = 5'h00;
    src_vec[`RSS_FLAG_EXTERNAL] = ext_long_low;
    src_vec[`RSS_FLAG_BROWNOUT] = bod_enabled & bod_low_in;
    src_vec[`RSS_FLAG_WATCHDOG] = wdt_pulse;
    src_vec[`RSS_FLAG_SCAN]     = scan_reset_reg_in;
  end

  // Power-on is the asynchronous reset itself; the rest are ORed
  assign any_request = |src_vec;

  // Ports clear asynchronously via the power-on reset; other sources
  // gate combinationally so no clock edge is needed for the port reset.
  assign port_reset_n_out = rstn_in & ~any_request & ~wdt_pulse_d;

  // ****************************************************************
  // Delay counter
  // ****************************************************************
  function automatic logic [15:0] tout_for(input logic [3:0] sel);
    tout_for = sel[3] ? 16'(TOUT_LONG_CYC) : 16'(TOUT_SHORT_CYC);
  endfunction

  rss_pkg::rss_state_e state;
  rss_pkg::rss_state_e next_state;
  logic [15:0] cnt;
  logic [15:0] next_cnt;

  always_comb
  begin
    next_state = state;
    next_cnt = cnt;
    case (state)
      rss_pkg::RSS_HOLD:
      begin
        // Watchdog: count starts on the clock edge after wdt_pulse_d falls, two clocks after its pulse ends
        if (!any_request && !wdt_pulse_d)
        begin
          next_state = rss_pkg::RSS_STRETCH;
          next_cnt = tout_for(clock_select_fuses_in);
        end
      end
      rss_pkg::RSS_STRETCH:
      begin
        if (any_request)
          next_state = rss_pkg::RSS_HOLD;
        else if (cnt <= 16'h0001)
          next_state = rss_pkg::RSS_RUN;
        else
          next_cnt = cnt - 16'h0001;
      end
      default:
      begin
        if (any_request)
          next_state = rss_pkg::RSS_HOLD;
      end
    endcase
  end

  always_ff @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      state <= rss_pkg::RSS_HOLD;
      cnt <= 16'h0000;
    end
    else
    begin
      state <= next_state;
      cnt <= next_cnt;
    end
  end

  // Combinational drop on a new request so the core stops at once
  assign core_reset_n_out = (state == rss_pkg::RSS_RUN) & ~any_request;
  assign fetch_from_vector_out = (state == rss_pkg::RSS_STRETCH) &&
                                 (next_state == rss_pkg::RSS_RUN);

  // ****************************************************************
  // Cause flags
  // ****************************************************************
  logic [4:0] cause;
  logic [4:0] next_cause;
  logic       por_seen;
  always_comb
  begin
    next_cause = cause;
    for (int i = 0; i < `RSS_NUM_SOURCES; i++)
    begin
      if (cause_write_in[i] && !cause_wdata_in[i])
        next_cause[i] = 1'b0;
    end
    // Set wins over a clear in the same cycle
    next_cause = next_cause | src_vec;
    if (!por_seen)
      next_cause[`RSS_FLAG_SUPPLY_UP] = 1'b1;
  end

  always_ff @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      cause <= `RSS_CAUSE_RESET;
      por_seen <= 1'b0;
    end
    else
    begin
      cause <= next_cause;
      por_seen <= 1'b1;
    end
  end
  assign reset_cause_register_out = cause;

  // ****************************************************************
  // Sleep gating and scan port
  // ****************************************************************
  // Idle is the only sleep mode that keeps the I/O clock running
  function automatic logic io_clk_stops(input logic       sleeping,
                                        input logic [2:0] mode);
    io_clk_stops = sleeping && (mode != 3'(rss_pkg::RSS_IDLE));
  endfunction

  // Only the two standby modes keep the oscillator in deep sleep;
  // reserved codes are treated like power-down, the cheapest choice
  function automatic logic osc_stops(input logic       sleeping,
                                     input logic [2:0] mode);
    osc_stops = io_clk_stops(sleeping, mode)
      && (mode != 3'(rss_pkg::RSS_STBY))
      && (mode != 3'(rss_pkg::RSS_XSTBY));
  endfunction

  logic deep_sleep;
  logic io_clk_stop;
  assign deep_sleep = io_clk_stops(sleep_in, sleep_mode_in);
  assign io_clk_stop = deep_sleep;

  assign scan_iface_en_out = scan_iface_enable_fuse_in &
                             ~scan_iface_disable_bit_in;
  // Debug keeps the clock only while the scan interface can reach it
  assign main_clk_keep_out = ~osc_stops(sleep_in, sleep_mode_in)
    | (onchip_debug_fuse_in & scan_iface_en_out);
  assign input_buf_en_out = ~io_clk_stop | wake_pin_need_in;
  assign comp_en_out = ~comp_disable_in & ~deep_sleep;
  assign vref_en_out = bod_enabled
    | (comp_use_ref_in & ~comp_disable_in);
  assign bod_en_out = bod_enabled;
  assign wdt_run_out = wdt_enable_in;

  // Data and enable are registered together so the pin never shows
  // a new level with a stale enable
  logic next_tdo;
  logic next_tdo_oe_n;
  always_comb
  begin
    next_tdo = scan_tdo_in;
    // Float the pin whenever no shift is in progress
    next_tdo_oe_n = ~(scan_iface_en_out & scan_shifting_in);
  end

  always_ff @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      scan_tdo_out <= 1'b0;
      scan_tdo_oe_n_out <= 1'b1;
    end
    else
    begin
      scan_tdo_out <= next_tdo;
      scan_tdo_oe_n_out <= next_tdo_oe_n;
    end
  end
endmodule
`default_nettype wire

/* File: testbench/rss_partner.sv */
// External reset circuit and scan debug host for the reset sequencer.
// Assumes one go pulse per request, driven just after a clock edge.
`default_nettype none
module rss_partner (
  // Control from the bench
  input  wire logic       clk_in,
  input  wire logic       go_in,
  input  wire logic       scan_sel_in,
  input  wire logic [7:0] len_in,
  // Reset pin and scan reset register
  output logic            pin_n_out,
  output logic            scan_reg_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] cnt = 8'h00;
  logic       sel = 1'b0;
  always @(posedge clk_in)
  begin
    if (go_in)
    begin
      cnt <= len_in;
      sel <= scan_sel_in;
    end
    else if (cnt != 8'h00)
      cnt <= cnt - 8'h01;
  end
  // Pin has a pull-up, so it reads high once released
  assign pin_n_out = !(cnt != 8'h00 && !sel);
  // Host shifts a zero in when the count runs out
  assign scan_reg_out = cnt != 8'h00 && sel;
endmodule
`default_nettype wire

/* File: testbench/rss_top_checker.sv */
// Checker for rss_top: reset timing and sleep gating at its ports.
// Assumes TOUT_SHORT_CYC of at least four cycles.
`default_nettype none
module rss_top_checker (
  input wire logic       clk_in, rstn_in, wdt_expire_in, wdt_enable_in,
  input wire logic       bod_low_in, scan_reset_reg_in, onchip_debug_fuse_in,
  input wire logic [2:0] brownout_level_fuses_in, sleep_mode_in,
  input wire logic       scan_iface_enable_fuse_in, scan_iface_disable_bit_in,
  input wire logic       sleep_in, comp_use_ref_in, scan_shifting_in,
  input wire logic       scan_tdo_oe_n_out, scan_iface_en_out,
  input wire logic       port_reset_n_out, core_reset_n_out,
  input wire logic       fetch_from_vector_out, main_clk_keep_out,
  input wire logic       comp_en_out, vref_en_out, bod_en_out, wdt_run_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rstn_in);
  scan_hold_a: assert property (scan_reset_reg_in |-> ##[0:1]
    !port_reset_n_out && !core_reset_n_out) else $error("scan hold");
  wdt_pulse_a: assert property ($rose(wdt_expire_in) && wdt_enable_in
    |-> ##[0:2] !core_reset_n_out) else $error("watchdog reset missing");
  bod_reset_a: assert property (bod_low_in &&
    brownout_level_fuses_in != 3'h7 |-> ##[0:1] !core_reset_n_out)
    else $error("brown-out reset missing");
  stretch_min_a: assert property ($rose(core_reset_n_out) |->
    $past(port_reset_n_out, 3)) else $error("reset not stretched");
  fetch_next_a: assert property (fetch_from_vector_out |=>
    $rose(core_reset_n_out)) else $error("fetch pulse misplaced");
  scan_off_a: assert property (scan_iface_disable_bit_in ||
    !scan_iface_enable_fuse_in |-> !scan_iface_en_out)
    else $error("scan interface not disabled");
  tdo_float_a: assert property (scan_iface_en_out |=>
    scan_tdo_oe_n_out == !$past(scan_shifting_in)) else $error("tdo drive");
  comp_sleep_a: assert property (sleep_in && sleep_mode_in != 3'h0 &&
    !comp_use_ref_in |-> !comp_en_out) else $error("comparator on");
  bod_keep_a: assert property (brownout_level_fuses_in != 3'h7
    |-> bod_en_out && vref_en_out) else $error("brown-out or ref off");
  wdt_keep_a: assert property (wdt_enable_in |-> wdt_run_out)
    else $error("watchdog stopped");
  clk_keep_a: assert property (onchip_debug_fuse_in &&
    scan_iface_en_out && sleep_in && sleep_mode_in inside {3'h2, 3'h3}
    |-> main_clk_keep_out) else $error("main clock dropped");
endmodule
bind rss_top rss_top_checker u_rss_top_checker (.clk_in(clk_in),
  .rstn_in(rstn_in), .wdt_expire_in(wdt_expire_in),
  .wdt_enable_in(wdt_enable_in), .bod_low_in(bod_low_in),
  .scan_reset_reg_in(scan_reset_reg_in), .sleep_mode_in(sleep_mode_in),
  .onchip_debug_fuse_in(onchip_debug_fuse_in), .sleep_in(sleep_in),
  .brownout_level_fuses_in(brownout_level_fuses_in),
  .scan_iface_enable_fuse_in(scan_iface_enable_fuse_in),
  .scan_iface_disable_bit_in(scan_iface_disable_bit_in),
  .comp_use_ref_in(comp_use_ref_in), .scan_shifting_in(scan_shifting_in),
  .scan_tdo_oe_n_out(scan_tdo_oe_n_out), .vref_en_out(vref_en_out),
  .scan_iface_en_out(scan_iface_en_out), .comp_en_out(comp_en_out),
  .port_reset_n_out(port_reset_n_out), .core_reset_n_out(core_reset_n_out),
  .fetch_from_vector_out(fetch_from_vector_out), .wdt_run_out(wdt_run_out),
  .main_clk_keep_out(main_clk_keep_out), .bod_en_out(bod_en_out));
`default_nettype wire

/* File: testbench/rss_top_test.sv */
// Bench for rss_top: reset sources, stretch timing, flags, sleep gating.
// Assumes rss_partner drives the reset pin and the scan reset register.
`default_nettype none
module rss_top_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_in = 1'b0, rstn_in = 1'b0, go = 1'b0, sel = 1'b0;
  logic wex = 1'b0, wen = 1'b0, bodl = 1'b0, dbgf = 1'b0, jef = 1'b1;
  logic jd = 1'b0, slp = 1'b0, useref = 1'b0, sh = 1'b0, tdi = 1'b0;
  logic [7:0] len = 8'h00;
  logic [3:0] cks = 4'h0;
  logic [2:0] bodf = 3'h7, mode = 3'h0;
  logic [4:0] cw = 5'h00, cwd = 5'h00, cause;
  logic wake = 1'b0, cdis = 1'b0, fetch;
  logic pin_n, sreg, tdo, oe_n, ien, prst_n, crst_n, keep, ibuf, cmp;
  logic vref, boden, wrun;
  logic [2:0] modes [5] = '{3'h0, 3'h2, 3'h3, 3'h6, 3'h7};
  int fail_count = 0, checks = 0, d0, d1;
  always #50 clk_in = ~clk_in;
  rss_partner u_rss_partner (.clk_in(clk_in), .go_in(go), .scan_sel_in(sel),
    .len_in(len), .pin_n_out(pin_n), .scan_reg_out(sreg));
  // Short stretch counts keep the run brief
  rss_top #(.TOUT_SHORT_CYC(4), .TOUT_LONG_CYC(8)) u_rss_top (
    .clk_in(clk_in), .rstn_in(rstn_in), .ext_reset_n_in(pin_n),
    .wdt_expire_in(wex), .wdt_enable_in(wen), .bod_low_in(bodl),
    .scan_reset_reg_in(sreg), .clock_select_fuses_in(cks),
    .brownout_level_fuses_in(bodf), .onchip_debug_fuse_in(dbgf),
    .scan_iface_enable_fuse_in(jef), .scan_iface_disable_bit_in(jd),
    .cause_write_in(cw), .cause_wdata_in(cwd), .sleep_in(slp),
    .sleep_mode_in(mode), .comp_disable_in(cdis), .comp_use_ref_in(useref),
    .wake_pin_need_in(wake), .scan_shifting_in(sh), .scan_tdo_in(tdi),
    .scan_tdo_out(tdo), .scan_tdo_oe_n_out(oe_n), .scan_iface_en_out(ien),
    .port_reset_n_out(prst_n), .core_reset_n_out(crst_n),
    .fetch_from_vector_out(fetch), .reset_cause_register_out(cause),
    .main_clk_keep_out(keep), .input_buf_en_out(ibuf), .comp_en_out(cmp),
    .vref_en_out(vref), .bod_en_out(boden), .wdt_run_out(wrun));
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Bounded wait for the core to leave reset, counting cycles
  task automatic run(output int n);
    n = 0;
    while (crst_n !== 1'b1 && n < 200)
    begin
      cyc(1);
      n++;
    end
    chk(16'(n < 200), 16'h0001);
  endtask
  task automatic pulse(input logic s, input logic [7:0] l);
    sel = s;
    len = l;
    go = 1'b1;
    cyc(1);
    go = 1'b0;
  endtask
  task automatic clr;
    cw = 5'h1f;
    cyc(1);
    cw = 5'h00;
  endtask
  task automatic conclude;
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial
  begin
    cyc(2);
    rstn_in = 1'b1;
    run(d0);
    chk(16'(d0), 16'h0005);
    chk(cause, 5'h01);
    clr;
    chk(cause, 5'h00);
    pulse(1'b0, 8'd10);
    cyc(40);
    chk(crst_n, 1'b1);
    pulse(1'b0, 8'd40);
    cyc(30);
    chk({prst_n, crst_n}, 2'b00);
    run(d0);
    chk(cause, 5'h02);
    cwd = 5'h1f;
    clr;
    chk(cause, 5'h02);
    cwd = 5'h00;
    cyc(1);
    clr;
    wex = 1'b1;
    cyc(1);
    wex = 1'b0;
    cyc(3);
    chk(crst_n, 1'b1);
    wen = 1'b1;
    wex = 1'b1;
    cyc(1);
    wex = 1'b0;
    cyc(1);
    chk(crst_n, 1'b0);
    cyc(5);
    chk({fetch, crst_n}, 2'b10);
    cyc(1);
    chk({fetch, crst_n}, 2'b01);
    run(d0);
    chk(cause, 5'h08);
    clr;
    bodl = 1'b1;
    cyc(3);
    chk(crst_n, 1'b1);
    bodf = 3'h4;
    cyc(2);
    chk(crst_n, 1'b0);
    clr;
    chk(cause, 5'h04);
    bodl = 1'b0;
    run(d0);
    chk(cause, 5'h04);
    clr;
    pulse(1'b1, 8'd20);
    cyc(1);
    chk(crst_n, 1'b0);
    run(d0);
    chk(cause, 5'h10);
    cks = 4'h8;
    clr;
    pulse(1'b1, 8'd20);
    cyc(1);
    run(d1);
    chk(16'(d1 - d0), 16'h0004);
    // Supply loss in mid-run: ports and flags drop with no clock edge
    rstn_in = 1'b0;
    #1;
    chk({prst_n, crst_n, cause}, 7'h00);
    cyc(2);
    rstn_in = 1'b1;
    run(d0);
    chk(16'(d0), 16'h0009);
    chk(cause, 5'h01);
    dbgf = 1'b1;
    slp = 1'b1;
    foreach (modes[i])
    begin
      mode = modes[i];
      cyc(1);
      chk({ibuf, cmp}, {2{mode == 3'h0}});
      chk({wrun, boden}, 2'b11);
      if (mode inside {3'h2, 3'h3})
        chk(keep, 1'b1);
    end
    dbgf = 1'b0;
    bodf = 3'h7;
    mode = 3'h2;
    wake = 1'b1;
    cyc(1);
    chk({keep, vref, ibuf}, 3'b001);
    useref = 1'b1;
    cyc(1);
    chk(vref, 1'b1);
    slp = 1'b0;
    cdis = 1'b1;
    cyc(2);
    chk({ien, oe_n}, 2'b11);
    chk({cmp, vref}, 2'b00);
    cdis = 1'b0;
    wake = 1'b0;
    sh = 1'b1;
    tdi = 1'b1;
    cyc(2);
    chk({oe_n, tdo}, 2'b01);
    jd = 1'b1;
    cyc(1);
    chk(ien, 1'b0);
    jd = 1'b0;
    jef = 1'b0;
    cyc(1);
    chk(ien, 1'b0);
    conclude;
  end
  // Tests need well under the 20000 cycles that this limit allows
  initial
  begin
    #2000000;
    fail_count++;
    conclude;
  end
endmodule
`default_nettype wire
